// [hw/osc_cal_pkg.sv]
// Purpose: Shared constants for the oscillator digital calibration block.
// Assumes: Register addresses are byte offsets on the device register port.
// Notes:   Period lengths are powers of two counted in stage ticks.
package osc_cal_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_XT_TRIM   = 8'h14;
  localparam logic [7:0] ADDR_RC_UPPER  = 8'h15;
  localparam logic [7:0] ADDR_RC_LOWER  = 8'h16;
  localparam logic [7:0] ADDR_OSC_STATE = 8'h1D;

  // Field positions.
  localparam int XT_COARSE_BIT  = 7;
  localparam int XT_COUNT_W     = 7;
  localparam int RC_RANGE_LSB   = 6;
  localparam int RC_HIGH_W      = 6;
  localparam int RC_COUNT_W     = 14;
  localparam int EXT_TRIM_LSB   = 6;
  localparam int OSC_SRC_BIT    = 4;
  localparam int FAIL_BIT       = 1;

  // Values after reset.
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [1:0] EXT_RESET  = 2'h0;

  // Stage rates and the longest calibration periods, in hertz and seconds.
  localparam int XT_STAGE_HZ        = 16384;
  localparam int XT_PERIOD_S        = 32;
  localparam int RC_STAGE_HZ        = 64;
  localparam int RC_PERIOD_S        = 8192;
  // Both longest periods hold the same count of stage ticks.
  localparam int PERIOD_TICKS       = XT_STAGE_HZ * XT_PERIOD_S;
  localparam int PERIOD_BITS        = $clog2(PERIOD_TICKS);

  // Pulses removed per extended trim step: 64 per 32 s, 32 per 16 s.
  localparam logic [15:0] EXT_PULSES_NORMAL = 16'h0040;
  localparam logic [15:0] EXT_PULSES_COARSE = 16'h0020;

  // Magnitude of a signed trim, used by both paths.
  function automatic logic [14:0] trim_magnitude(input logic signed [15:0] v);
    logic [15:0] m;
    m = v[15] ? 16'(-v) : 16'(v);
    return m[14:0];
  endfunction

endpackage

// [hw/cal_pulse_spreader.sv]
// Purpose: Spreads a count of corrections evenly over one calibration period.
// Assumes: Magnitude and period shift only change at a period boundary.
// Notes:   Period length is 2**(PERIOD_BITS - period_shift) stage ticks.
`timescale 1ns/1ps
module cal_pulse_spreader #(
  parameter int PERIOD_BITS = 19,
  parameter int MAG_W       = 15
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Stage timing
  input  wire logic             enable,
  input  wire logic             stage_tick,
  input  wire logic [1:0]       period_shift,
  input  wire logic [MAG_W-1:0] magnitude,
  // Results
  output logic                  corr,
  output logic                  period_end
);

  logic [PERIOD_BITS-1:0] tick_cnt_reg;
  logic [PERIOD_BITS-1:0] tick_cnt_next;
  logic [PERIOD_BITS:0]   acc_reg;
  logic [PERIOD_BITS:0]   acc_next;
  wire  [PERIOD_BITS:0]   len_w;
  wire  [PERIOD_BITS+1:0] sum_w;
  wire  [PERIOD_BITS+1:0] rem_w;

  // Accumulator overflows exactly magnitude times per period and ends at zero.
  assign len_w      = {1'b1, {PERIOD_BITS{1'b0}}} >> period_shift;
  assign sum_w      = {1'b0, acc_reg} + (PERIOD_BITS+2)'(magnitude);
  assign rem_w      = sum_w - {1'b0, len_w};
  assign corr       = stage_tick && (sum_w >= {1'b0, len_w});
  assign period_end = stage_tick && ({1'b0, tick_cnt_reg} == len_w - 1'b1);

  always_comb begin
    tick_cnt_next = tick_cnt_reg;
    acc_next      = acc_reg;
    if (!enable) begin
      tick_cnt_next = '0;
      acc_next      = '0;
    end else if (period_end) begin
      tick_cnt_next = '0;
      acc_next      = '0;
    end else if (stage_tick) begin
      tick_cnt_next = tick_cnt_reg + 1'b1;
      acc_next      = corr ? rem_w[PERIOD_BITS:0] : sum_w[PERIOD_BITS:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
      acc_reg      <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      acc_reg      <= acc_next;
    end
  end

endmodule

// [hw/cal_stage_editor.sv]
// Purpose: Divides a fast tick by two and gates or inserts one stage pulse.
// Assumes: A correction is flagged on a base tick and applies to the next cycle.
// Notes:   An inserted pulse lands on the half-cycle edge, so jitter stays
//          within one stage period.
`timescale 1ns/1ps
module cal_stage_editor (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Fast level ticks
  input  wire logic enable,
  input  wire logic fast_tick,
  // Correction request
  input  wire logic corr,
  input  wire logic corr_add,
  // Stage ticks
  output logic      base_tick,
  output logic      out_tick
);

  logic phase_reg;
  logic phase_next;
  logic pend_reg;
  logic pend_next;
  logic pend_add_reg;
  logic pend_add_next;
  logic out_tick_reg;
  logic out_tick_next;
  wire  gate_w;
  wire  add_w;

  assign base_tick     = fast_tick & phase_reg;
  assign gate_w        = pend_reg & ~pend_add_reg;
  assign add_w         = pend_reg & pend_add_reg;
  assign phase_next    = enable & (fast_tick ? ~phase_reg : phase_reg);
  // A new correction wins over the clear of the one just applied.
  assign pend_next     = enable & (corr | (pend_reg & ~base_tick));
  assign pend_add_next = corr ? corr_add : pend_add_reg;
  assign out_tick_next = enable & fast_tick & (phase_reg ? ~gate_w : add_w);
  assign out_tick      = out_tick_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg    <= 1'b0;
      pend_reg     <= 1'b0;
      pend_add_reg <= 1'b0;
      out_tick_reg <= 1'b0;
    end else begin
      phase_reg    <= phase_next;
      pend_reg     <= pend_next;
      pend_add_reg <= pend_add_next;
      out_tick_reg <= out_tick_next;
    end
  end

endmodule

// [hw/osc_digital_cal.sv]
// Purpose: Distributed digital calibration of the crystal and RC timebases.
// Assumes: Oscillator level clocks arrive asynchronously and are far slower
//          than clk_sys; the register port and autocal logic share clk_sys.
// Notes:   Trim edits take effect at the next period boundary of the path.
`timescale 1ns/1ps

module osc_digital_cal
  import osc_cal_pkg::*;
#(
  parameter int PERIOD_W = PERIOD_BITS
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Oscillator levels and source
  input  wire logic       xt_clk_in,
  input  wire logic       rc_clk_in,
  input  wire logic       oscillator_source_select,
  // Factory calibration values
  input  wire logic [7:0] factory_xt_trim,
  input  wire logic [7:0] factory_rc_upper,
  input  wire logic [7:0] factory_rc_lower,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Autocalibration results
  input  wire logic       autocal_done,
  input  wire logic       autocal_fail,
  input  wire logic [7:0] autocal_rc_upper,
  input  wire logic [7:0] autocal_rc_lower,
  // Calibrated stage ticks and period end
  output logic            xt_cal_tick,
  output logic            rc_cal_tick,
  output logic            cal_period_end
);

  logic [7:0]  xt_trim_reg;
  logic [7:0]  rc_upper_reg;
  logic [7:0]  rc_lower_reg;
  logic [1:0]  ext_trim_reg;
  logic        fail_flag_reg;
  logic        load_pending_reg;
  logic [7:0]  xt_shadow_reg;
  logic [7:0]  xt_shadow_next;
  logic [1:0]  ext_shadow_reg;
  logic [1:0]  ext_shadow_next;
  logic [15:0] rc_shadow_reg;
  logic [15:0] rc_shadow_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        period_end_reg;
  logic [2:0]  xt_sync_reg;
  logic [2:0]  rc_sync_reg;

  wire         wr_xt;
  wire         wr_rcu;
  wire         wr_rcl;
  wire         wr_osc;
  wire         autocal_ok;
  wire [7:0]   xt_trim_next;
  wire [7:0]   rc_upper_next;
  wire [7:0]   rc_lower_next;
  wire [1:0]   ext_trim_next;
  wire         fail_flag_next;
  wire         xt_enable;
  wire         rc_enable;
  wire         xt_fast_tick;
  wire         rc_fast_tick;
  wire signed [15:0] xt_net;
  wire signed [15:0] rc_net;
  wire [15:0]  ext_pulses;
  wire [14:0]  xt_mag;
  wire [14:0]  rc_mag;
  wire         xt_base_tick;
  wire         rc_base_tick;
  wire         xt_corr;
  wire         rc_corr;
  wire         xt_period_end;
  wire         rc_period_end;

  // Register write decode.
  assign wr_xt  = reg_wr_en && (reg_addr == ADDR_XT_TRIM);
  assign wr_rcu = reg_wr_en && (reg_addr == ADDR_RC_UPPER);
  assign wr_rcl = reg_wr_en && (reg_addr == ADDR_RC_LOWER);
  assign wr_osc = reg_wr_en && (reg_addr == ADDR_OSC_STATE);
  assign autocal_ok = autocal_done && !autocal_fail;

  // A host write in the same cycle as an autocal result wins the register.
  assign xt_trim_next  = wr_xt ? reg_wdata : xt_trim_reg;
  assign rc_upper_next = wr_rcu ? reg_wdata :
                         autocal_ok ? autocal_rc_upper : rc_upper_reg;
  assign rc_lower_next = wr_rcl ? reg_wdata :
                         autocal_ok ? autocal_rc_lower : rc_lower_reg;
  assign ext_trim_next = wr_osc ? reg_wdata[EXT_TRIM_LSB +: 2] : ext_trim_reg;
  // A failure in the cycle of a clearing write still leaves the flag set.
  assign fail_flag_next = (autocal_done && autocal_fail) ||
                          (fail_flag_reg && !(wr_osc && !reg_wdata[FAIL_BIT]));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      load_pending_reg <= 1'b1;
      xt_trim_reg      <= REG_RESET;
      rc_upper_reg     <= REG_RESET;
      rc_lower_reg     <= REG_RESET;
    end else if (load_pending_reg) begin
      load_pending_reg <= 1'b0;
      xt_trim_reg      <= factory_xt_trim;
      rc_upper_reg     <= factory_rc_upper;
      rc_lower_reg     <= factory_rc_lower;
    end else begin
      xt_trim_reg      <= xt_trim_next;
      rc_upper_reg     <= rc_upper_next;
      rc_lower_reg     <= rc_lower_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_trim_reg  <= EXT_RESET;
      fail_flag_reg <= 1'b0;
    end else begin
      ext_trim_reg  <= ext_trim_next;
      fail_flag_reg <= fail_flag_next;
    end
  end

  // Oscillator levels: two flops, then an edge flop that reads only the second.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xt_sync_reg <= 3'h0;
      rc_sync_reg <= 3'h0;
    end else begin
      xt_sync_reg <= {xt_sync_reg[1:0], xt_clk_in};
      rc_sync_reg <= {rc_sync_reg[1:0], rc_clk_in};
    end
  end

  assign xt_enable    = !oscillator_source_select;
  assign rc_enable    = oscillator_source_select;
  assign xt_fast_tick = xt_enable && xt_sync_reg[1] && !xt_sync_reg[2];
  assign rc_fast_tick = rc_enable && rc_sync_reg[1] && !rc_sync_reg[2];

  // Shadows hold the trim of the period in progress so a write cannot
  // disturb its count; an idle path follows the registers directly.
  assign xt_shadow_next  = load_pending_reg ? factory_xt_trim :
                           (xt_period_end || !xt_enable) ? xt_trim_reg :
                           xt_shadow_reg;
  assign ext_shadow_next = (xt_period_end || !xt_enable) ? ext_trim_reg :
                           ext_shadow_reg;
  assign rc_shadow_next  = load_pending_reg ? {factory_rc_upper, factory_rc_lower} :
                           (rc_period_end || !rc_enable) ?
                           {rc_upper_reg, rc_lower_reg} : rc_shadow_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xt_shadow_reg  <= REG_RESET;
      ext_shadow_reg <= EXT_RESET;
      rc_shadow_reg  <= {REG_RESET, REG_RESET};
    end else begin
      xt_shadow_reg  <= xt_shadow_next;
      ext_shadow_reg <= ext_shadow_next;
      rc_shadow_reg  <= rc_shadow_next;
    end
  end

  // Net crystal correction: signed count less the extended pulls.
  assign ext_pulses = xt_shadow_reg[XT_COARSE_BIT] ?
                      16'(ext_shadow_reg) * EXT_PULSES_COARSE :
                      16'(ext_shadow_reg) * EXT_PULSES_NORMAL;
  assign xt_net = $signed({{(16-XT_COUNT_W){xt_shadow_reg[XT_COUNT_W-1]}},
                           xt_shadow_reg[XT_COUNT_W-1:0]}) -
                  $signed(ext_pulses);
  assign rc_net = $signed({{(16-RC_COUNT_W){rc_shadow_reg[RC_COUNT_W-1]}},
                           rc_shadow_reg[RC_COUNT_W-1:0]});
  assign xt_mag = trim_magnitude(xt_net);
  assign rc_mag = trim_magnitude(rc_net);

  // Crystal path: 32.768 kHz edges feed the 16.384 kHz stage.
  cal_stage_editor u_xt_edit (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .enable    (xt_enable),
    .fast_tick (xt_fast_tick),
    .corr      (xt_corr),
    .corr_add  (!xt_net[15]),
    .base_tick (xt_base_tick),
    .out_tick  (xt_cal_tick)
  );

  // Period of 2**19 ticks (32 s) or 2**18 ticks (16 s) in coarse mode.
  cal_pulse_spreader #(
    .PERIOD_BITS (PERIOD_W),
    .MAG_W       (15)
  ) u_xt_spread (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .enable       (xt_enable),
    .stage_tick   (xt_base_tick),
    .period_shift ({1'b0, xt_shadow_reg[XT_COARSE_BIT]}),
    .magnitude    (xt_mag),
    .corr         (xt_corr),
    .period_end   (xt_period_end)
  );

  // RC path: 128 Hz edges feed the 64 Hz stage.
  cal_stage_editor u_rc_edit (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .enable    (rc_enable),
    .fast_tick (rc_fast_tick),
    .corr      (rc_corr),
    .corr_add  (!rc_net[15]),
    .base_tick (rc_base_tick),
    .out_tick  (rc_cal_tick)
  );

  // Range 0..3 shortens the 8192 s period by halves and doubles the step.
  cal_pulse_spreader #(
    .PERIOD_BITS (PERIOD_W),
    .MAG_W       (15)
  ) u_rc_spread (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .enable       (rc_enable),
    .stage_tick   (rc_base_tick),
    .period_shift (rc_shadow_reg[8+RC_RANGE_LSB +: 2]),
    .magnitude    (rc_mag),
    .corr         (rc_corr),
    .period_end   (rc_period_end)
  );

  // Read data is registered, so it follows the address by one cycle.
  assign rdata_next = (reg_addr == ADDR_XT_TRIM)  ? xt_trim_reg :
                      (reg_addr == ADDR_RC_UPPER) ? rc_upper_reg :
                      (reg_addr == ADDR_RC_LOWER) ? rc_lower_reg :
                      (reg_addr == ADDR_OSC_STATE) ?
                      {ext_trim_reg, 1'b0, oscillator_source_select, 2'b00,
                       fail_flag_reg, 1'b0} : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg      <= 8'h00;
      period_end_reg <= 1'b0;
    end else begin
      rdata_reg      <= rdata_next;
      period_end_reg <= xt_period_end || rc_period_end;
    end
  end

  assign reg_rdata      = rdata_reg;
  assign cal_period_end = period_end_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_host_xt_write;
    !load_pending_reg && wr_xt;
  endsequence

  AST_FACTORY_XT: assert property (load_pending_reg |=>
    xt_trim_reg == $past(factory_xt_trim))
    else $error("Crystal trim did not load the factory value.");
  AST_FACTORY_RC: assert property (load_pending_reg |=>
    {rc_upper_reg, rc_lower_reg} == $past({factory_rc_upper, factory_rc_lower}))
    else $error("RC trim did not load the factory values.");
  AST_HOST_XT_WRITE: assert property (s_host_xt_write ##1 !reg_wr_en |=>
    xt_trim_reg == $past(reg_wdata, 2))
    else $error("Host write to the crystal trim was lost.");
  AST_AUTOCAL_LOAD: assert property (autocal_ok && !reg_wr_en && !load_pending_reg
    |=> rc_upper_reg == $past(autocal_rc_upper) && rc_lower_reg == $past(autocal_rc_lower))
    else $error("Autocal result was not loaded.");
  AST_AUTOCAL_FAIL: assert property (autocal_done && autocal_fail && !reg_wr_en
    && !load_pending_reg |=> $stable({rc_upper_reg, rc_lower_reg}) && fail_flag_reg)
    else $error("Failed autocal changed the RC trim.");
  AST_SHADOW_HOLD: assert property (xt_enable && !xt_period_end && !load_pending_reg
    |=> $stable(xt_shadow_reg))
    else $error("Crystal trim changed inside a period.");
  AST_XT_ONLY_SELECTED: assert property (xt_cal_tick |-> $past(xt_enable))
    else $error("Crystal stage tick while RC is selected.");
  AST_RC_ONLY_SELECTED: assert property (rc_cal_tick |-> $past(rc_enable))
    else $error("RC stage tick while crystal is selected.");
  AST_XT_SPACING: assert property (xt_cal_tick |=> !xt_cal_tick [*2])
    else $error("Crystal stage ticks closer than a fast edge.");
  AST_XT_MAG_RANGE: assert property (xt_mag <= 15'd256)
    else $error("Crystal correction count exceeds its range.");

endmodule

// [verification/trim_host.sv]
// Purpose: Host model that writes and reads the trim registers.
// Assumes: One register access at a time, launched just after a clock edge.
// Notes:   Reads wait two edges because read data is registered.
`timescale 1ns/1ps
module trim_host
  import osc_cal_pkg::*;
(
  // Clock
  input  wire logic       clk_sys,
  // Register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr_en = 1'b0;
    // Data is not held past the write, so a stale value cannot pass.
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    d = reg_rdata;
  endtask

  // Clearing all trim fields first keeps a measured output uncorrected.
  task automatic zero_trims();
    wr(ADDR_XT_TRIM, 8'h00);
    wr(ADDR_RC_UPPER, 8'h00);
    wr(ADDR_RC_LOWER, 8'h00);
    wr(ADDR_OSC_STATE, 8'h00);
  endtask
endmodule

// [verification/tb.sv]
// Purpose: Self-checking bench for the oscillator digital calibration block.
// Assumes: A short period parameter and fast oscillator levels keep runs brief.
// Notes:   Tick counts are taken between two consecutive period ends.
`timescale 1ns/1ps
module tb
  import osc_cal_pkg::*;
;
  localparam int PW      = 6;
  localparam int TMO     = 90000;
  localparam int GAP_MAX = 80;

  typedef struct packed {
    logic       src;
    logic [7:0] xt;
    logic [7:0] up;
    logic [7:0] lo;
    logic [1:0] ext;
    logic [7:0] n;
    logic       gap;
  } row_s;

  logic       clk_sys;
  logic       rst_n;
  logic       xt_clk_in;
  logic       rc_clk_in;
  logic       src;
  logic [7:0] f_xt;
  logic [7:0] f_up;
  logic [7:0] f_lo;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] ac_up;
  logic [7:0] ac_lo;
  logic [7:0] d;
  logic       reg_wr_en;
  logic       ac_done;
  logic       ac_fail;
  logic       xt_cal_tick;
  logic       rc_cal_tick;
  logic       cal_period_end;
  int         num_errors;
  int         compares;
  int         n;
  int         g;
  int         o;

  // Period is 64 base ticks; coarse halves it, each RC range step halves it.
  row_s rows [11] = '{
    '{1'b0, 8'h00, 8'h00, 8'h00, 2'h0, 8'h40, 1'b1},
    '{1'b0, 8'h03, 8'h00, 8'h00, 2'h0, 8'h43, 1'b1},
    '{1'b0, 8'h7D, 8'h00, 8'h00, 2'h0, 8'h3D, 1'b1},
    '{1'b0, 8'h82, 8'h00, 8'h00, 2'h0, 8'h22, 1'b1},
    '{1'b0, 8'h08, 8'h00, 8'h00, 2'h1, 8'h08, 1'b0},
    '{1'b0, 8'h40, 8'h00, 8'h00, 2'h0, 8'h00, 1'b0},
    '{1'b0, 8'h3F, 8'h00, 8'h00, 2'h0, 8'h7F, 1'b0},
    '{1'b1, 8'h00, 8'h00, 8'h05, 2'h0, 8'h45, 1'b1},
    '{1'b1, 8'h00, 8'hFF, 8'hFE, 2'h0, 8'h06, 1'b1},
    '{1'b1, 8'h00, 8'h40, 8'h04, 2'h0, 8'h24, 1'b1},
    '{1'b1, 8'h00, 8'h80, 8'h03, 2'h0, 8'h13, 1'b1}
  };

  osc_digital_cal #(.PERIOD_W(PW)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .xt_clk_in(xt_clk_in),
    .rc_clk_in(rc_clk_in), .oscillator_source_select(src),
    .factory_xt_trim(f_xt), .factory_rc_upper(f_up), .factory_rc_lower(f_lo),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .autocal_done(ac_done), .autocal_fail(ac_fail),
    .autocal_rc_upper(ac_up), .autocal_rc_lower(ac_lo),
    .xt_cal_tick(xt_cal_tick), .rc_cal_tick(rc_cal_tick),
    .cal_period_end(cal_period_end)
  );

  trim_host host (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Oscillator levels run far faster than real parts, unrelated in phase.
  initial begin
    xt_clk_in = 1'b0;
    forever #212 xt_clk_in = ~xt_clk_in;
  end

  initial begin
    rc_clk_in = 1'b0;
    forever #237 rc_clk_in = ~rc_clk_in;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic summarize();
    $display("Checks: %0d, errors: %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk("outputs in reset", 16'h0, {5'h0, reg_rdata, xt_cal_tick, rc_cal_tick,
        cal_period_end});
    rst_n = 1'b1;
    rd_chk("factory xt", ADDR_XT_TRIM, f_xt);
    rd_chk("factory rc upper", ADDR_RC_UPPER, f_up);
    rd_chk("factory rc lower", ADDR_RC_LOWER, f_lo);
    rd_chk("state after reset", ADDR_OSC_STATE, {3'b000, src, 4'h0});
  endtask

  task automatic autocal(input logic f, input logic [7:0] u, input logic [7:0] l);
    @(posedge clk_sys);
    #1;
    ac_done = 1'b1;
    ac_fail = f;
    ac_up   = u;
    ac_lo   = l;
    @(posedge clk_sys);
    #1;
    ac_done = 1'b0;
    ac_up   = ~u;
    ac_lo   = ~l;
  endtask

  task automatic wait_end();
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      #1;
      k++;
    end while (cal_period_end !== 1'b1 && k < 20000);
    chk("period end seen", 16'h1, {15'h0, cal_period_end});
  endtask

  task automatic measure(input logic s, input logic gj);
    n = 0;
    o = 0;
    g = 0;
    do begin
      @(posedge clk_sys);
      #1;
      g++;
      if ((s ? rc_cal_tick : xt_cal_tick) === 1'b1) begin
        n++;
        // The first gap runs from the period start and is not judged.
        // Heavy gating leaves long gaps by design, so only flagged rows are judged.
        if (gj && n > 1 && g > GAP_MAX) begin
          chk("tick gap", 16'(GAP_MAX), 16'(g));
        end
        g = 0;
      end
      if ((s ? xt_cal_tick : rc_cal_tick) === 1'b1) begin
        o++;
      end
    end while (cal_period_end !== 1'b1 && n < 400);
  endtask

  initial begin
    #(25 * TMO);
    num_errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    src = 1'b0;
    f_xt = 8'h85;
    f_up = 8'hC7;
    f_lo = 8'h1A;
    ac_done = 1'b0;
    ac_fail = 1'b0;
    ac_up = 8'h00;
    ac_lo = 8'h00;
    num_errors = 0;
    compares = 0;
    do_reset();
    host.zero_trims();
    foreach (rows[i]) begin
      @(posedge clk_sys);
      #1;
      src = rows[i].src;
      host.wr(ADDR_XT_TRIM, rows[i].xt);
      host.wr(ADDR_RC_UPPER, rows[i].up);
      host.wr(ADDR_RC_LOWER, rows[i].lo);
      host.wr(ADDR_OSC_STATE, {rows[i].ext, 6'h00});
      wait_end();
      // The first period after a change still carries the last correction of
      // the old trim, so the count is taken over the period after it.
      wait_end();
      measure(rows[i].src, rows[i].gap);
      chk("ticks per period", {8'h00, rows[i].n}, 16'(n));
      chk("idle path ticks", 16'h0, 16'(o));
    end
    host.wr(ADDR_OSC_STATE, 8'hFF);
    rd_chk("state read-only bits", ADDR_OSC_STATE, 8'hD0);
    host.wr(8'h20, 8'h5A);
    rd_chk("unmapped read", 8'h20, 8'h00);
    rd_chk("xt after unmapped", ADDR_XT_TRIM, 8'h00);
    autocal(1'b0, 8'h4B, 8'hD2);
    rd_chk("autocal upper", ADDR_RC_UPPER, 8'h4B);
    rd_chk("autocal lower", ADDR_RC_LOWER, 8'hD2);
    autocal(1'b1, 8'h11, 8'h22);
    rd_chk("failed upper", ADDR_RC_UPPER, 8'h4B);
    rd_chk("failed lower", ADDR_RC_LOWER, 8'hD2);
    rd_chk("fail flag set", ADDR_OSC_STATE, 8'hD2);
    host.wr(ADDR_OSC_STATE, 8'hC2);
    rd_chk("fail flag kept", ADDR_OSC_STATE, 8'hD2);
    host.wr(ADDR_OSC_STATE, 8'hC0);
    rd_chk("fail flag cleared", ADDR_OSC_STATE, 8'hD0);
    // Host write and autocal in one cycle: the host byte wins, the other lands.
    fork
      host.wr(ADDR_RC_UPPER, 8'h33);
      autocal(1'b0, 8'h99, 8'h77);
    join
    rd_chk("host beats autocal", ADDR_RC_UPPER, 8'h33);
    rd_chk("autocal lower kept", ADDR_RC_LOWER, 8'h77);
    @(posedge clk_sys);
    #1;
    do_reset();
    summarize();
  end
endmodule
